//--- core/cct_timer.sv
// Two-channel capture/compare timer with modulo counter and linked buffered compare
`timescale 1ns/1ps

module cct_timer (
  input wire logic clock,
  input wire logic reset,
  input wire logic counter_stop,
  input wire logic counter_reset,
  input wire logic [2:0] prescale_select,
  input wire logic external_timer_clock_pin,
  input wire logic modulo_write,
  input wire logic [7:0] modulo_limit_high,
  input wire logic [7:0] modulo_limit_low,
  input wire logic overflow_irq_enable,
  input wire logic overflow_flag_clear,
  input wire logic [1:0] channel_compare_mode,
  input wire logic [1:0] edge_level_select_hi,
  input wire logic [1:0] edge_level_select_lo,
  input wire logic [1:0] toggle_on_overflow,
  input wire logic [1:0] channel_irq_enable,
  input wire logic [1:0] channel_flag_clear,
  input wire logic buffered_link_select,
  input wire logic [1:0] channel_value_write,
  input wire logic [7:0] channel_value_high,
  input wire logic [7:0] channel_value_low,
  input wire logic channel0_pin_in,
  input wire logic channel1_pin_in,
  output logic channel0_pin_out,
  output logic channel0_pin_oe,
  output logic channel1_pin_out,
  output logic channel1_pin_oe,
  output logic [15:0] counter_value,
  output logic [15:0] channel0_value,
  output logic [15:0] channel1_value,
  output logic overflow_flag,
  output logic channel0_event_flag,
  output logic channel1_event_flag,
  output logic overflow_irq,
  output logic channel0_irq,
  output logic channel1_irq,
  output logic active_set
);

  cct_pkg::cct_state_t s_r;
  cct_pkg::cct_state_t s_nxt;
  cct_pkg::cct_chan_t chv_r;
  cct_pkg::cct_chan_t chv_nxt;
  logic tick;
  logic run_tick;
  logic ovf_evt;
  logic [1:0] cap_evt;
  logic [1:0] cmp_evt;
  logic [1:0] els;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [15:0] cmp_value;
  logic [1:0] ch_off;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel == cct_pkg::ELS_RISE_OR_TOGGLE && r) || (sel == cct_pkg::ELS_FALL_OR_CLEAR && f)
      || (sel == cct_pkg::ELS_ANY_OR_SET && (r || f));
  endfunction

  function automatic logic pin_action(input logic [1:0] sel, input logic cur);
    unique case (sel)
      cct_pkg::ELS_RISE_OR_TOGGLE: pin_action = ~cur;
      cct_pkg::ELS_FALL_OR_CLEAR: pin_action = 1'b0;
      cct_pkg::ELS_ANY_OR_SET: pin_action = 1'b1;
      cct_pkg::ELS_OFF: pin_action = cur;
    endcase
  endfunction

  cct_prescaler #(
    .DIV_W(cct_pkg::PS_CNT_W)
  ) u_prescaler (
    .clock(clock),
    .reset(reset),
    .clear(counter_reset),
    .prescale_select(prescale_select),
    .ext_tick(s_r.ext_s2 & ~s_r.ext_s3),
    .tick(tick)
  );

  assign run_tick = tick && !counter_stop && !counter_reset;

  always_comb
  begin
    s_nxt = s_r;
    chv_nxt = chv_r;
    ovf_evt = 1'b0;
    cap_evt = 2'b00;
    cmp_evt = 2'b00;
    cmp_value = 16'h0000;
    // Pin synchronisers
    s_nxt.pin_s1 = {channel1_pin_in, channel0_pin_in};
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_s3 = s_r.pin_s2;
    s_nxt.ext_s1 = external_timer_clock_pin;
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_s3 = s_r.ext_s2;
    rise = s_r.pin_s2 & ~s_r.pin_s3;
    fall = ~s_r.pin_s2 & s_r.pin_s3;
    els = 2'b00;
    // Channel 1 is idle while linked
    ch_off = {buffered_link_select, 1'b0};

    if (counter_reset)
      s_nxt.cnt = cct_pkg::COUNT_RESET;
    else if (run_tick)
    begin
      if (s_r.cnt == s_r.modulo)
      begin
        s_nxt.cnt = cct_pkg::COUNT_RESET;
        ovf_evt = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt + 16'h0001;
    end
    if (modulo_write)
      s_nxt.modulo = {modulo_limit_high, modulo_limit_low};

    // Linked buffered compare: last written set takes over at overflow
    if (!buffered_link_select)
    begin
      s_nxt.active_set = 1'b0;
      s_nxt.pending_set = 1'b0;
    end
    else
    begin
      if (channel_value_write[1])
        s_nxt.pending_set = 1'b1;
      else if (channel_value_write[0])
        s_nxt.pending_set = 1'b0;
      if (ovf_evt)
        s_nxt.active_set = s_nxt.pending_set;
    end

    for (int i = 0; i < cct_pkg::NUM_CH; i++)
    begin
      els = {edge_level_select_hi[i], edge_level_select_lo[i]};
      if (channel_value_write[i])
        chv_nxt.value[i] = {channel_value_high, channel_value_low};
      if (!ch_off[i] && !channel_compare_mode[i])
      begin
        cap_evt[i] = edge_hit(els, rise[i], fall[i]);
        if (cap_evt[i])
          chv_nxt.value[i] = s_r.cnt;
      end
      if (!ch_off[i] && channel_compare_mode[i])
      begin
        cmp_value = (i == 0 && buffered_link_select && s_r.active_set) ? chv_r.value[1] : chv_r.value[i];
        cmp_evt[i] = run_tick && s_nxt.cnt == cmp_value;
        if (ovf_evt && toggle_on_overflow[i])
          s_nxt.pin_out[i] = ~s_r.pin_out[i];
        if (cmp_evt[i])
          s_nxt.pin_out[i] = pin_action(els, s_nxt.pin_out[i]);
      end
      s_nxt.pin_oe[i] = !ch_off[i] && channel_compare_mode[i] && els != cct_pkg::ELS_OFF;
      // Set wins over clear
      s_nxt.ch_flag[i] = (s_r.ch_flag[i] && !channel_flag_clear[i]) || cap_evt[i] || cmp_evt[i];
      s_nxt.ch_irq[i] = s_nxt.ch_flag[i] && channel_irq_enable[i];
    end

    s_nxt.ovf_flag = (s_r.ovf_flag && !overflow_flag_clear) || ovf_evt;
    s_nxt.ovf_irq = s_nxt.ovf_flag && overflow_irq_enable;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.modulo <= cct_pkg::MODULO_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // Channel values survive reset
  always_ff @(posedge clock)
  begin
    chv_r <= chv_nxt;
  end

  assign counter_value = s_r.cnt;
  assign channel0_value = chv_r.value[0];
  assign channel1_value = chv_r.value[1];
  assign channel0_pin_out = s_r.pin_out[0];
  assign channel0_pin_oe = s_r.pin_oe[0];
  assign channel1_pin_out = s_r.pin_out[1];
  assign channel1_pin_oe = s_r.pin_oe[1];
  assign overflow_flag = s_r.ovf_flag;
  assign channel0_event_flag = s_r.ch_flag[0];
  assign channel1_event_flag = s_r.ch_flag[1];
  assign overflow_irq = s_r.ovf_irq;
  assign channel0_irq = s_r.ch_irq[0];
  assign channel1_irq = s_r.ch_irq[1];
  assign active_set = s_r.active_set;

  a_count_wraps: assert property (@(posedge clock) disable iff (reset)
    run_tick && s_r.cnt == s_r.modulo |=> s_r.cnt == 16'h0000)
    else $error("Counter did not wrap to zero after limit");

  a_count_steps: assert property (@(posedge clock) disable iff (reset)
    run_tick && s_r.cnt != s_r.modulo |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("Counter did not step by one");

  a_count_holds: assert property (@(posedge clock) disable iff (reset)
    !run_tick && !counter_reset |=> $stable(s_r.cnt))
    else $error("Counter moved without a tick");

  a_ovf_flag_irq: assert property (@(posedge clock) disable iff (reset)
    run_tick && s_r.cnt == s_r.modulo && overflow_irq_enable ##1 overflow_irq_enable |->
    s_r.ovf_flag && s_r.ovf_irq)
    else $error("Overflow did not set flag and request");

  a_capture_value: assert property (@(posedge clock) disable iff (reset)
    !channel_compare_mode[0] && edge_level_select_hi[0] && edge_level_select_lo[0] && (s_r.pin_s2[0] != s_r.pin_s3[0])
    |=> chv_r.value[0] == $past(s_r.cnt) && s_r.ch_flag[0])
    else $error("Capture did not latch counter");

  a_capture_delay: assert property (@(posedge clock) disable iff (reset)
    !channel_compare_mode[1] && !buffered_link_select && edge_level_select_lo[1] && !edge_level_select_hi[1]
    && $stable(channel_compare_mode[1]) && $stable(edge_level_select_lo[1]) && $rose(s_r.pin_s2[1])
    |=> s_r.ch_flag[1])
    else $error("Capture flag late after synchronised edge");

  a_irq_gated: assert property (@(posedge clock) disable iff (reset)
    !s_r.ch_flag[0] || !channel_irq_enable[0] |=> ##0 !$past(channel_irq_enable[0]) |-> !s_r.ch_irq[0])
    else $error("Channel request without enable");

  a_cmp_clear: assert property (@(posedge clock) disable iff (reset)
    cmp_evt[0] && edge_level_select_hi[0] && !edge_level_select_lo[0] |=> !channel0_pin_out)
    else $error("Clear on compare did not clear pin");

  a_tov_toggle: assert property (@(posedge clock) disable iff (reset)
    ovf_evt && channel_compare_mode[0] && toggle_on_overflow[0] && !cmp_evt[0]
    |=> channel0_pin_out != $past(channel0_pin_out))
    else $error("Pin did not toggle on overflow");

  a_link_release: assert property (@(posedge clock) disable iff (reset)
    buffered_link_select |-> !cmp_evt[1] && !cap_evt[1] ##1 !channel1_pin_oe)
    else $error("Channel 1 active while linked");

  a_link_swap: assert property (@(posedge clock) disable iff (reset)
    buffered_link_select && channel_value_write[1] && !channel_value_write[0] && ovf_evt |=> s_r.active_set)
    else $error("Linked set did not pass to channel 1 at overflow");

endmodule // cct_timer

//--- core/cct_pkg.sv
// Shared constants and types for the two-channel capture/compare timer
package cct_pkg;

  localparam int CNT_W = 16;
  localparam int PS_CNT_W = 6;
  localparam int NUM_CH = 2;

  // Values after reset
  localparam logic [15:0] MODULO_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [5:0] PS_COUNT_RESET = 6'h00;

  // Prescaler select codes
  localparam logic [2:0] PS_DIV1 = 3'h0;
  localparam logic [2:0] PS_EXT_CLOCK = 3'h7;

  // Edge/level select pair {hi, lo}
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_RISE_OR_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_FALL_OR_CLEAR = 2'h2;
  localparam logic [1:0] ELS_ANY_OR_SET = 2'h3;

  typedef struct packed {
    logic [5:0] div_cnt;
    logic tick;
  } cct_ps_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] modulo;
    logic ovf_flag;
    logic [1:0] ch_flag;
    logic ovf_irq;
    logic [1:0] ch_irq;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic active_set;
    logic pending_set;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
  } cct_state_t;

  typedef struct packed {
    logic [1:0][15:0] value;
  } cct_chan_t;

endpackage

//--- core/cct_prescaler.sv
// Counter clock prescaler: seven bus clock rates or the external clock tick
`timescale 1ns/1ps
module cct_prescaler #(
  parameter int DIV_W = cct_pkg::PS_CNT_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clear,
  input wire logic [2:0] prescale_select,
  input wire logic ext_tick,
  output logic tick
);

  cct_pkg::cct_ps_state_t s_r;
  cct_pkg::cct_ps_state_t s_nxt;

  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    div_mask = DIV_W'((1 << sel) - 1);
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    if (clear)
    begin
      s_nxt.div_cnt = cct_pkg::PS_COUNT_RESET;
      s_nxt.tick = 1'b0;
    end
    else
    begin
      s_nxt.div_cnt = s_r.div_cnt + 6'h01;
      if (prescale_select == cct_pkg::PS_EXT_CLOCK)
        s_nxt.tick = ext_tick;
      else
        s_nxt.tick = (s_r.div_cnt & div_mask(prescale_select)) == div_mask(prescale_select);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

endmodule // cct_prescaler

//--- tb/cct_far_side.sv
// Far-side model: levels on the two channel pins and the external clock pin
`timescale 1ns/1ps
module cct_far_side (
  input wire logic clock,
  output logic ch0_pin,
  output logic ch1_pin,
  output logic ext_pin
);
  initial
  begin
    ch0_pin = 1'b0;
    ch1_pin = 1'b0;
    ext_pin = 1'b0;
  end
  // Levels {ext, ch1, ch0} change just after a bus clock edge
  task automatic drive(input logic [2:0] lvl);
    @(posedge clock);
    {ext_pin, ch1_pin, ch0_pin} <= lvl;
  endtask
endmodule // cct_far_side

//--- tb/test_cct_timer.sv
// Self-checking bench for the two-channel capture/compare timer
`timescale 1ns/1ps
module test_cct_timer;
  logic clock = 0, reset = 1, counter_stop = 0, counter_reset = 0, modulo_write = 0;
  logic [2:0] prescale_select = 3'h0;
  logic [7:0] modulo_limit_high = 8'h00, modulo_limit_low = 8'h00;
  logic [7:0] channel_value_high = 8'h00, channel_value_low = 8'h00;
  logic overflow_irq_enable = 0, overflow_flag_clear = 0, buffered_link_select = 0;
  logic [1:0] channel_compare_mode = 2'h0, edge_level_select_hi = 2'h0, edge_level_select_lo = 2'h0;
  logic [1:0] toggle_on_overflow = 2'h0, channel_irq_enable = 2'h0, channel_flag_clear = 2'h0;
  logic [1:0] channel_value_write = 2'h0;
  logic p0, p1, pe, channel0_pin_out, channel0_pin_oe, channel1_pin_out, channel1_pin_oe;
  logic [15:0] counter_value, channel0_value, channel1_value;
  logic overflow_flag, channel0_event_flag, channel1_event_flag;
  logic overflow_irq, channel0_irq, channel1_irq, active_set;
  int fail_count = 0, checks_done = 0, s, n, k, md, m;
  logic [15:0] base;

  cct_far_side far (.clock, .ch0_pin(p0), .ch1_pin(p1), .ext_pin(pe));
  cct_timer dut (.clock, .reset, .counter_stop, .counter_reset, .prescale_select,
    .external_timer_clock_pin(pe), .modulo_write, .modulo_limit_high, .modulo_limit_low,
    .overflow_irq_enable, .overflow_flag_clear, .channel_compare_mode, .edge_level_select_hi,
    .edge_level_select_lo, .toggle_on_overflow, .channel_irq_enable, .channel_flag_clear,
    .buffered_link_select, .channel_value_write, .channel_value_high, .channel_value_low,
    .channel0_pin_in(p0), .channel1_pin_in(p1), .channel0_pin_out, .channel0_pin_oe,
    .channel1_pin_out, .channel1_pin_oe, .counter_value, .channel0_value, .channel1_value,
    .overflow_flag, .channel0_event_flag, .channel1_event_flag, .overflow_irq,
    .channel0_irq, .channel1_irq, .active_set);

  always #12.5 clock = ~clock;

  task automatic results();
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  // Writes a 16-bit value: w 0/1 channel, 2 modulo limit
  task automatic wr(input int w, input logic [15:0] v);
    @(posedge clock);
    {modulo_limit_high, modulo_limit_low} <= v;
    {channel_value_high, channel_value_low} <= v;
    modulo_write <= (w == 2);
    channel_value_write <= (w == 2) ? 2'h0 : 2'(1 << w);
    @(posedge clock);
    modulo_write <= 0;
    channel_value_write <= 2'h0;
  endtask

  // Samples while the watched signal (0 pin, 1 overflow flag) equals lvl
  task automatic span(input int w, input logic lvl, output int c);
    c = 0;
    while (((w == 0) ? channel0_pin_out : overflow_flag) === lvl && c < 600)
    begin
      c++;
      cyc(1);
    end
    if (c == 600)
    begin
      fail_count++;
      results();
    end
  endtask

  task automatic restart(input logic [15:0] lim);
    @(posedge clock) counter_reset <= 1;
    wr(2, lim);
    @(posedge clock) counter_reset <= 0;
  endtask

  initial
  begin
    void'($urandom(32'h1ee4));
    repeat (16) @(posedge clock);
    reset <= 0;
    for (s = 0; s < 7; s++)
    begin
      @(posedge clock) prescale_select <= 3'(s);
      restart(16'hffff);
      cyc(8);
      base = counter_value;
      cyc(64);
      chk(counter_value - base, 16'(64 >> s));
    end
    @(posedge clock) prescale_select <= 3'h7;
    cyc(8);
    base = counter_value;
    repeat (5)
    begin
      far.drive(3'h4);
      far.drive(3'h4);
      far.drive(3'h0);
      far.drive(3'h0);
    end
    cyc(6);
    chk(counter_value - base, 16'h0005);
    md = 2 + $urandom % 6;
    @(posedge clock)
    begin
      prescale_select <= 3'h0;
      overflow_irq_enable <= 1;
    end
    restart(16'(md));
    span(1, 0, n);
    chk(counter_value, 16'h0000);
    chk(overflow_irq, 1'b1);
    m = 0;
    for (k = 0; k < 3 * md; k++)
    begin
      cyc(1);
      m = (m == md) ? 0 : m + 1;
      chk(counter_value, 16'(m));
    end
    @(posedge clock) counter_stop <= 1;
    m = (m == md) ? 0 : m + 1;
    // Both channels capture rising edges; only channel 1 may interrupt
    edge_level_select_lo <= 2'h3;
    channel_irq_enable <= 2'h2;
    far.drive(3'h3);
    cyc(3);
    chk(channel1_value, 16'(m));
    chk(channel0_value, 16'(m));
    chk({channel1_irq, channel0_irq}, 2'h2);
    @(posedge clock) counter_stop <= 0;
    repeat (3) @(posedge clock);
    counter_stop <= 1;
    m = (m + 3) % (md + 1);
    far.drive(3'h0);
    far.drive(3'h3);
    cyc(3);
    chk(channel1_value, 16'(m));
    chk(channel1_event_flag, 1'b1);
    // Clearing both flags drops the channel 1 request
    @(posedge clock) channel_flag_clear <= 2'h3;
    @(posedge clock) channel_flag_clear <= 2'h0;
    cyc(1);
    chk({channel1_event_flag, channel0_event_flag}, 2'h0);
    chk(channel1_irq, 1'b0);
    // Channel 0 high-pulse PWM, 256-cycle period
    @(posedge clock)
    begin
      channel_compare_mode <= 2'h1;
      edge_level_select_hi <= 2'h1;
      edge_level_select_lo <= 2'h0;
      toggle_on_overflow <= 2'h1;
    end
    wr(0, 16'h0080);
    restart(16'h00ff);
    @(posedge clock) counter_stop <= 0;
    span(0, 0, n);
    span(0, 1, n);
    chk(16'(n), 16'h0080);
    span(0, 0, n);
    chk(16'(n), 16'h0080);
    // Larger value written at overflow shortens the low part
    wr(0, 16'h00a0);
    span(0, 1, n);
    span(0, 0, n);
    chk(16'(n), 16'h0060);
    chk(channel0_pin_oe, 1'b1);
    chk(channel0_irq, 1'b0);
    // Channel 1 set to toggle compare, which linking must silence
    @(posedge clock)
    begin
      buffered_link_select <= 1;
      channel_compare_mode <= 2'h3;
      edge_level_select_lo <= 2'h2;
    end
    cyc(2);
    chk(channel1_pin_oe, 1'b0);
    chk(active_set, 1'b0);
    wr(1, 16'h0040);
    @(posedge clock) overflow_flag_clear <= 1;
    @(posedge clock) overflow_flag_clear <= 0;
    cyc(1);
    chk(active_set, 1'b0);
    span(1, 0, n);
    chk(active_set, 1'b1);
    span(0, 1, n);
    chk(16'(n), 16'h0040);
    results();
  end
endmodule // test_cct_timer
